/* src/fcd_pkg.sv */
// Purpose: Shared constants and types for the flash command sequencer
// Assumes: 125 MHz clock, 16-bit word-addressed flash
// Notes: Strobe widths are plain defaults, tune for the part in use
package fcd_pkg;
  localparam int CLK_MHZ   = 125;
  localparam int T_WP_NS   = 35;
  localparam int T_ACC_NS  = 90;
  localparam int T_SUSP_US = 20;
  // Least times round up
  localparam int WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int SUSP_CYC  = T_SUSP_US * CLK_MHZ;
  localparam int AW        = 22;
  localparam int DW        = 16;
  localparam int B_POLL    = 7;
  localparam int B_TMO     = 5;

  localparam logic [21:0] A_555 = 22'h000555;
  localparam logic [21:0] A_2AA = 22'h0002aa;
  localparam logic [21:0] A_55  = 22'h000055;
  localparam logic [21:0] A_ANY = 22'h000000;

  localparam logic [7:0] D_AA = 8'haa;
  localparam logic [7:0] D_55 = 8'h55;
  localparam logic [7:0] D_90 = 8'h90;
  localparam logic [7:0] D_A0 = 8'ha0;
  localparam logic [7:0] D_20 = 8'h20;
  localparam logic [7:0] D_80 = 8'h80;
  localparam logic [7:0] D_10 = 8'h10;
  localparam logic [7:0] D_30 = 8'h30;
  localparam logic [7:0] D_B0 = 8'hb0;
  localparam logic [7:0] D_F0 = 8'hf0;
  localparam logic [7:0] D_98 = 8'h98;
  localparam logic [7:0] D_88 = 8'h88;
  localparam logic [7:0] D_00 = 8'h00;

  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_RESET      = 4'h1,
    OP_AUTOSEL    = 4'h2,
    OP_PROGRAM    = 4'h3,
    OP_BYP_ENTER  = 4'h4,
    OP_BYP_PROG   = 4'h5,
    OP_BYP_EXIT   = 4'h6,
    OP_CHIP_ERASE = 4'h7,
    OP_SECT_ERASE = 4'h8,
    OP_SECT_ADD   = 4'h9,
    OP_ERASE_WAIT = 4'ha,
    OP_SUSPEND    = 4'hb,
    OP_RESUME     = 4'hc,
    OP_CFI        = 4'hd,
    OP_SEC_ENTER  = 4'he,
    OP_SEC_EXIT   = 4'hf
  } fcd_op_e;

  typedef struct packed {
    logic [21:0] a;
    logic [15:0] d;
    logic        rd;
  } fcd_step_s;
endpackage

/* src/fcd_bus_if.sv */
// Purpose: One flash bus cycle request and its answer
// Assumes: req is a one-cycle pulse, done a one-cycle pulse
// Notes: q holds the word of the last read cycle
`timescale 1ns/1ps
interface fcd_bus_if;
  logic        req;
  logic        rd;
  logic [21:0] a;
  logic [15:0] d;
  logic        done;
  logic [15:0] q;
  modport master (output req, rd, a, d, input done, q);
  modport slave  (input req, rd, a, d, output done, q);
endinterface

/* src/fcd_cycle.sv */
// Purpose: Drives one read or write cycle on the flash pins
// Assumes: Flash data input synchronous to clock
// Notes: Setup, strobe, hold, release; data outlives the write strobe
`timescale 1ns/1ps
module fcd_cycle #(
  parameter int WP_CYC  = fcd_pkg::WP_CYC,
  parameter int ACC_CYC = fcd_pkg::ACC_CYC
) (
  input  logic        clock,
  input  logic        rst,
  fcd_bus_if.slave    bus,
  output logic [21:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic        fl_dq_oe_n,
  input  logic [15:0] fl_dq_in,
  output logic        fl_ce_n,
  output logic        fl_we_n,
  output logic        fl_oe_n
);
  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_SETUP = 3'b001,
    C_STRB  = 3'b010,
    C_HOLD  = 3'b011,
    C_DONE  = 3'b100
  } fcd_cst_e;

  typedef struct packed {
    fcd_cst_e    st;
    logic [7:0]  cnt;
    logic        rd;
    logic [21:0] a;
    logic [15:0] d;
    logic [15:0] q;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        dq_oe_n;
  } fcd_cyc_s;

  localparam fcd_cyc_s CYC_RST = '{st: C_IDLE, cnt: 8'h00, rd: 1'b0, a: 22'h000000,
    d: 16'h0000, q: 16'h0000, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1};

  fcd_cyc_s s_r;
  fcd_cyc_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      C_IDLE: begin
        if (bus.req) begin
          s_nxt.rd      = bus.rd;
          s_nxt.a       = bus.a;
          s_nxt.d       = bus.d;
          s_nxt.ce_n    = 1'b0;
          s_nxt.dq_oe_n = bus.rd;
          s_nxt.st      = C_SETUP;
        end
      end
      C_SETUP: begin
        // Address settles before the strobe falls
        s_nxt.we_n = s_r.rd;
        s_nxt.oe_n = !s_r.rd;
        s_nxt.cnt  = s_r.rd ? 8'(ACC_CYC - 1) : 8'(WP_CYC - 1);
        s_nxt.st   = C_STRB;
      end
      C_STRB: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.we_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st   = C_HOLD;
          if (s_r.rd) begin
            s_nxt.q = fl_dq_in;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      C_HOLD: begin
        // Data held one cycle past the rising strobe
        s_nxt.ce_n    = 1'b1;
        s_nxt.dq_oe_n = 1'b1;
        s_nxt.st      = C_DONE;
      end
      C_DONE: begin
        s_nxt.st = C_IDLE;
      end
      default: begin
        s_nxt = CYC_RST;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= CYC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fl_addr    = s_r.a;
  assign fl_dq_out  = s_r.d;
  assign fl_dq_oe_n = s_r.dq_oe_n;
  assign fl_ce_n    = s_r.ce_n;
  assign fl_we_n    = s_r.we_n;
  assign fl_oe_n    = s_r.oe_n;
  assign bus.done   = (s_r.st == C_DONE);
  assign bus.q      = s_r.q;

  a_addr_stable: assert property (@(posedge clock) disable iff (rst)
    !fl_we_n |-> $stable(fl_addr) && !fl_ce_n)
    else $error("address moved during write strobe");
  a_data_at_rise: assert property (@(posedge clock) disable iff (rst)
    $rose(fl_we_n) |-> !fl_dq_oe_n && $stable(fl_dq_out))
    else $error("data not held at write strobe rise");
  a_strobe_width: assert property (@(posedge clock) disable iff (rst)
    $fell(fl_we_n) |-> (!fl_we_n)[*5] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_strobe_excl: assert property (@(posedge clock) disable iff (rst)
    !(!fl_we_n && !fl_oe_n) && !(!fl_oe_n && !fl_dq_oe_n))
    else $error("bus contention on flash pins");
endmodule

/* src/fcd_host.sv */
// Overview of operation
// - Single F0 write returns device to read
// - Autoselect: three writes then one read
// - Program is four writes, last starts it
// - Bypass entry, then two-write programs
// - Bypass exit: 90 then 00 anywhere
// - Erase is six writes, chip or sector
// - Poll program address until bit seven true
// - Erase polls zero until done or suspended
// - Take full data from a later read
// - Recheck bit seven after timeout flag
// - Extra sector addresses within 50 us window
// Purpose: Host controller issuing flash command sequences
// Assumes: One command at a time; cmd_op held with cmd_valid
// Notes: No poll timer; long erases poll until bit seven or the timeout flag ends them
`timescale 1ns/1ps
module fcd_host (
  input  logic              clock,
  input  logic              rst,
  input  logic              cmd_valid,
  output logic              cmd_ready,
  input  fcd_pkg::fcd_op_e  cmd_op,
  input  logic [21:0]       cmd_addr,
  input  logic [15:0]       cmd_data,
  output logic              rsp_valid,
  output logic              rsp_fail,
  output logic [15:0]       rsp_data,
  output logic [21:0]       fl_addr,
  output logic [15:0]       fl_dq_out,
  output logic              fl_dq_oe_n,
  input  logic [15:0]       fl_dq_in,
  output logic              fl_ce_n,
  output logic              fl_we_n,
  output logic              fl_oe_n,
  output logic              fl_rst_n
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ISSUE = 3'b001,
    S_WAIT  = 3'b010,
    S_SUSP  = 3'b011,
    S_RESP  = 3'b100
  } fcd_hst_e;

  typedef enum logic [2:0] {
    PH_SEQ   = 3'b000,
    PH_POLL  = 3'b001,
    PH_RECHK = 3'b010,
    PH_FINAL = 3'b011,
    PH_ABORT = 3'b100
  } fcd_ph_e;

  typedef struct packed {
    fcd_hst_e         st;
    fcd_pkg::fcd_op_e op;
    fcd_ph_e          ph;
    logic [2:0]       idx;
    logic [21:0]      addr;
    logic [15:0]      data;
    logic [11:0]      tmr;
    logic             req;
    logic             req_rd;
    logic [21:0]      req_a;
    logic [15:0]      req_d;
    logic [15:0]      rsp_d;
    logic             fail;
    logic             frst_n;
  } fcd_host_s;

  fcd_host_s          s_r;
  fcd_host_s          s_nxt;
  fcd_pkg::fcd_step_s stp;
  logic               expect_bit;
  logic               hit;

  fcd_bus_if bus ();

  fcd_cycle u_cycle (
    .clock      (clock),
    .rst        (rst),
    .bus        (bus),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_dq_in   (fl_dq_in),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n)
  );

  // Upper byte always driven zero on command writes
  function automatic fcd_pkg::fcd_step_s wr(input logic [21:0] a, input logic [7:0] d);
    wr = '{a: a, d: {8'h00, d}, rd: 1'b0};
  endfunction

  // Second unlock cycle when sec is set
  function automatic fcd_pkg::fcd_step_s unl(input logic sec);
    unl = sec ? wr(fcd_pkg::A_2AA, fcd_pkg::D_55) : wr(fcd_pkg::A_555, fcd_pkg::D_AA);
  endfunction

  function automatic logic [2:0] len_of(input fcd_pkg::fcd_op_e op);
    case (op)
      fcd_pkg::OP_AUTOSEL,
      fcd_pkg::OP_PROGRAM,
      fcd_pkg::OP_SEC_EXIT:    len_of = 3'h3;
      fcd_pkg::OP_BYP_ENTER,
      fcd_pkg::OP_SEC_ENTER:   len_of = 3'h2;
      fcd_pkg::OP_BYP_PROG,
      fcd_pkg::OP_BYP_EXIT:    len_of = 3'h1;
      fcd_pkg::OP_CHIP_ERASE,
      fcd_pkg::OP_SECT_ERASE:  len_of = 3'h5;
      default:                 len_of = 3'h0;
    endcase
  endfunction

  function automatic fcd_pkg::fcd_step_s step_of(input fcd_pkg::fcd_op_e op,
      input logic [2:0] i, input logic [21:0] a, input logic [15:0] d);
    step_of = (i >= 3'h3) ? unl(i == 3'h4) : unl(i == 3'h1);
    case (op)
      fcd_pkg::OP_READ: step_of = '{a: a, d: 16'h0000, rd: 1'b1};
      fcd_pkg::OP_RESET: step_of = wr(fcd_pkg::A_ANY, fcd_pkg::D_F0);
      fcd_pkg::OP_AUTOSEL: begin
        // Caller's address carries offset and sector bits
        if (i == 3'h3) step_of = '{a: a, d: 16'h0000, rd: 1'b1};
        else if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_90);
      end
      fcd_pkg::OP_PROGRAM: begin
        if (i == 3'h3) step_of = '{a: a, d: d, rd: 1'b0};
        else if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_A0);
      end
      fcd_pkg::OP_BYP_ENTER: begin
        if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_20);
      end
      fcd_pkg::OP_BYP_PROG: begin
        if (i == 3'h0) step_of = wr(fcd_pkg::A_ANY, fcd_pkg::D_A0);
        else step_of = '{a: a, d: d, rd: 1'b0};
      end
      fcd_pkg::OP_BYP_EXIT: begin
        step_of = wr(fcd_pkg::A_ANY, (i == 3'h0) ? fcd_pkg::D_90 : fcd_pkg::D_00);
      end
      fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECT_ERASE: begin
        if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_80);
        else if (i == 3'h5 && op == fcd_pkg::OP_CHIP_ERASE)
          step_of = wr(fcd_pkg::A_555, fcd_pkg::D_10);
        else if (i == 3'h5) step_of = wr(a, fcd_pkg::D_30);
      end
      // Another sector inside the open erase window
      fcd_pkg::OP_SECT_ADD: step_of = wr(a, fcd_pkg::D_30);
      fcd_pkg::OP_SUSPEND: step_of = wr(a, fcd_pkg::D_B0);
      fcd_pkg::OP_RESUME: step_of = wr(a, fcd_pkg::D_30);
      fcd_pkg::OP_CFI: step_of = wr(fcd_pkg::A_55, fcd_pkg::D_98);
      fcd_pkg::OP_SEC_ENTER: begin
        if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_88);
      end
      fcd_pkg::OP_SEC_EXIT: begin
        if (i == 3'h2) step_of = wr(fcd_pkg::A_555, fcd_pkg::D_90);
        else if (i == 3'h3) step_of = wr(fcd_pkg::A_ANY, fcd_pkg::D_00);
      end
      default: step_of = wr(fcd_pkg::A_ANY, fcd_pkg::D_F0);
    endcase
  endfunction

  function automatic logic is_poll(input fcd_pkg::fcd_op_e op);
    is_poll = (op == fcd_pkg::OP_PROGRAM) || (op == fcd_pkg::OP_BYP_PROG) ||
              (op == fcd_pkg::OP_CHIP_ERASE) || (op == fcd_pkg::OP_ERASE_WAIT);
  endfunction

  // Program polls for the true bit seven, erase for a one
  assign expect_bit = (s_r.op == fcd_pkg::OP_PROGRAM || s_r.op == fcd_pkg::OP_BYP_PROG) ?
                      s_r.data[fcd_pkg::B_POLL] : 1'b1;
  assign hit        = (bus.q[fcd_pkg::B_POLL] == expect_bit);
  assign stp        = step_of(s_r.op, s_r.idx, s_r.addr, s_r.data);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.req    = 1'b0;
    s_nxt.frst_n = 1'b1;
    case (s_r.st)
      S_IDLE: begin
        if (cmd_valid) begin
          s_nxt.op   = cmd_op;
          s_nxt.addr = cmd_addr;
          s_nxt.data = cmd_data;
          s_nxt.idx  = 3'h0;
          s_nxt.fail = 1'b0;
          s_nxt.ph   = (cmd_op == fcd_pkg::OP_ERASE_WAIT) ? PH_POLL : PH_SEQ;
          s_nxt.st   = S_ISSUE;
        end
      end
      S_ISSUE: begin
        s_nxt.req = 1'b1;
        s_nxt.st  = S_WAIT;
        case (s_r.ph)
          PH_SEQ: begin
            s_nxt.req_a  = stp.a;
            s_nxt.req_d  = stp.d;
            s_nxt.req_rd = stp.rd;
          end
          PH_ABORT: begin
            s_nxt.req_a  = fcd_pkg::A_ANY;
            s_nxt.req_d  = {8'h00, fcd_pkg::D_F0};
            s_nxt.req_rd = 1'b0;
          end
          default: begin
            // Status only valid at the program or erasing address
            s_nxt.req_a  = s_r.addr;
            s_nxt.req_d  = 16'h0000;
            s_nxt.req_rd = 1'b1;
          end
        endcase
      end
      S_WAIT: begin
        if (bus.done) begin
          s_nxt.st = S_ISSUE;
          case (s_r.ph)
            PH_SEQ: begin
              if (s_r.idx != len_of(s_r.op)) begin
                s_nxt.idx = s_r.idx + 3'h1;
              end else if (is_poll(s_r.op)) begin
                s_nxt.ph = PH_POLL;
              end else if (s_r.op == fcd_pkg::OP_SUSPEND) begin
                s_nxt.tmr = 12'(fcd_pkg::SUSP_CYC);
                s_nxt.st  = S_SUSP;
              end else begin
                s_nxt.rsp_d = bus.q;
                s_nxt.st    = S_RESP;
              end
            end
            PH_POLL: begin
              // Protected targets finish early; toggle bit unused
              if (hit) begin
                s_nxt.ph = PH_FINAL;
              end else if (bus.q[fcd_pkg::B_TMO]) begin
                s_nxt.ph = PH_RECHK;
              end
            end
            PH_RECHK: begin
              if (hit) begin
                s_nxt.ph = PH_FINAL;
              end else begin
                s_nxt.ph   = PH_ABORT;
                s_nxt.fail = 1'b1;
              end
            end
            PH_FINAL: begin
              // Low bits may lag bit seven, so this read is the data
              s_nxt.rsp_d = bus.q;
              s_nxt.st    = S_RESP;
            end
            default: begin
              s_nxt.st = S_RESP;
            end
          endcase
        end
      end
      S_SUSP: begin
        if (s_r.tmr <= 12'h001) begin
          s_nxt.st = S_RESP;
        end else begin
          s_nxt.tmr = s_r.tmr - 12'h001;
        end
      end
      S_RESP: begin
        s_nxt.st = S_IDLE;
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.req   = s_r.req;
  assign bus.rd    = s_r.req_rd;
  assign bus.a     = s_r.req_a;
  assign bus.d     = s_r.req_d;
  assign cmd_ready = (s_r.st == S_IDLE);
  assign rsp_valid = (s_r.st == S_RESP);
  assign rsp_fail  = s_r.fail;
  assign rsp_data  = s_r.rsp_d;
  assign fl_rst_n  = s_r.frst_n;

  a_prog_unlock: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_ISSUE && s_r.ph == PH_SEQ && s_r.idx == 3'h0 &&
    s_r.op == fcd_pkg::OP_PROGRAM |=> bus.req && bus.a == 22'h000555 && bus.d == 16'h00aa)
    else $error("program does not open with unlock");
  a_prog_word: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_ISSUE && s_r.ph == PH_SEQ && s_r.idx == 3'h3 &&
    s_r.op == fcd_pkg::OP_PROGRAM |=> bus.a == s_r.addr && bus.d == s_r.data && !bus.rd)
    else $error("program word cycle wrong");
  a_reset_word: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_ISSUE && s_r.ph == PH_SEQ && s_r.op == fcd_pkg::OP_RESET
    |=> bus.req && bus.d[7:0] == 8'hf0 && !bus.rd)
    else $error("reset command not F0");
  a_poll_addr: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_ISSUE && s_r.ph inside {PH_POLL, PH_RECHK, PH_FINAL}
    |=> bus.req && bus.rd && bus.a == $past(s_r.addr))
    else $error("poll read off target address");
  a_final_reread: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_WAIT && bus.done && s_r.ph == PH_POLL && hit
    |=> s_r.ph == PH_FINAL ##1 bus.req && bus.rd ##[2:40] rsp_valid)
    else $error("no confirming read after poll hit");
  a_tmo_recheck: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_WAIT && bus.done && s_r.ph == PH_POLL && !hit && bus.q[5]
    |=> s_r.ph == PH_RECHK ##1 bus.req && bus.rd)
    else $error("bit seven not rechecked after timeout flag");
  a_fail_abort: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_WAIT && bus.done && s_r.ph == PH_RECHK && !hit
    |=> ##1 bus.req && bus.d[7:0] == 8'hf0 ##[2:40] (rsp_valid && rsp_fail))
    else $error("failed operation not ended by reset");
  a_byp_first: assert property (@(posedge clock) disable iff (rst)
    s_r.st == S_ISSUE && s_r.ph == PH_SEQ && s_r.idx == 3'h0 &&
    s_r.op == fcd_pkg::OP_BYP_PROG |=> bus.d[7:0] == 8'ha0 ##[2:40] bus.req && bus.a == s_r.addr)
    else $error("bypass program cycles wrong");
  a_susp_hold: assert property (@(posedge clock) disable iff (rst)
    $rose(s_r.st == S_SUSP) |-> !rsp_valid[*8] ##1 s_r.tmr > 12'h9b0)
    else $error("suspend wait cut short");

  c_prog_done: cover property (@(posedge clock) disable iff (rst)
    rsp_valid && !rsp_fail && s_r.op == fcd_pkg::OP_PROGRAM);
  c_fail: cover property (@(posedge clock) disable iff (rst) rsp_valid && rsp_fail);
  c_autosel: cover property (@(posedge clock) disable iff (rst)
    rsp_valid && s_r.op == fcd_pkg::OP_AUTOSEL);
  c_suspend: cover property (@(posedge clock) disable iff (rst)
    rsp_valid && s_r.op == fcd_pkg::OP_SUSPEND);
endmodule

/* sim/fcd_flash_model.sv */
// Purpose: Behavioural flash device on the far side of the host
// Assumes: Strobe-edge driven, no clock; short busy counts
// Notes: Program at BAD_A never finishes and raises the timeout flag
`timescale 1ns/1ps
module fcd_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00a1, // Arbitrary value
  parameter logic [15:0] DEV_ID   = 16'h0b2c, // Arbitrary value
  parameter logic [21:0] BAD_A    = 22'h0003ff
) (
  input  logic [21:0] fl_addr,
  input  logic [15:0] fl_dq_out,
  input  logic        fl_dq_oe_n,
  input  logic        fl_ce_n,
  input  logic        fl_we_n,
  input  logic        fl_oe_n,
  input  logic        fl_rst_n,
  output logic [15:0] fl_dq_in
);
  logic [15:0] mem [int];
  logic [21:0] la;
  logic [21:0] pa;
  logic [15:0] pd;
  logic [15:0] q = 16'h0000;
  logic [2:0]  st = 3'd0;
  logic        asel = 1'b0;
  logic        byp = 1'b0;
  logic        prog = 1'b0;
  logic        erase = 1'b0;
  logic        tog = 1'b0;
  logic        tmo = 1'b0;
  int          busy = 0;
  assign fl_dq_in = q;
  always @(negedge fl_rst_n) begin
    st = 3'd0; asel = 1'b0; byp = 1'b0; busy = 0; tmo = 1'b0; erase = 1'b0;
  end
  always @(negedge fl_we_n) if (!fl_ce_n) la = fl_addr;
  always @(posedge fl_we_n) if (!fl_ce_n && !fl_dq_oe_n) wr(la[10:0], fl_dq_out);
  always @(negedge fl_oe_n) if (!fl_ce_n) rd(fl_addr);
  // Released bus must not keep showing the last word
  always @(posedge fl_oe_n) q = ~q;
  task automatic wr(input logic [10:0] a, input logic [15:0] w);
    logic [7:0] d;
    d = w[7:0];
    if (d == 8'hf0) begin
      st = 3'd0; asel = 1'b0; busy = 0; tmo = 1'b0; erase = 1'b0;
    end else if (st == 3'd3) begin
      pa = la; pd = w; prog = 1'b1; erase = 1'b0; busy = 3; tmo = (la == BAD_A); st = 3'd0;
    end else if (byp) begin
      if (d == 8'ha0) st = 3'd3;
      else if (d == 8'h90) st = 3'd7;
      else if (st == 3'd7 && d == 8'h00) begin byp = 1'b0; st = 3'd0; end
    end else if (asel && d == 8'h00) asel = 1'b0;
    else if (st == 3'd0 && a == 11'h555 && d == 8'haa) st = 3'd1;
    else if (st == 3'd1 && a == 11'h2aa && d == 8'h55) st = 3'd2;
    else if (st == 3'd2 && a == 11'h555) begin
      st = (d == 8'ha0) ? 3'd3 : (d == 8'h80) ? 3'd4 : 3'd0;
      asel = (d == 8'h90);
      byp = (d == 8'h20);
    end else if (st == 3'd4 && d == 8'haa) st = 3'd5;
    else if (st == 3'd5 && d == 8'h55) st = 3'd6;
    else if ((st == 3'd6 || erase) && (d == 8'h10 || d == 8'h30)) begin
      erase = 1'b1; prog = 1'b0; busy = 4; st = 3'd0;
    end else st = 3'd0;
  endtask
  task automatic rd(input logic [21:0] a);
    tog = ~tog;
    if (busy > 0) begin
      q = {8'h00, prog & ~pd[7], tog, tmo, 5'h00};
      if (!tmo) busy--;
      if (busy == 0 && prog) mem[int'(pa)] = pd;
      if (busy == 0 && erase) mem.delete();
      if (busy == 0) erase = 1'b0;
    end else if (asel)
      q = (a[1:0] == 2'd0) ? MAKER_ID : (a[1:0] == 2'd1) ? DEV_ID :
          (a[1:0] == 2'd2) ? 16'h0000 : 16'h0018;
    else q = mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endtask
endmodule

/* sim/fcd_host_tb.sv */
// Purpose: Self-checking bench for the flash command host
// Assumes: Inputs change at falling edges
// Notes: One response awaited per command, bounded wait
`timescale 1ns/1ps
module fcd_host_tb;
  typedef struct packed {
    fcd_pkg::fcd_op_e op;
    logic [21:0]      a;
    logic [15:0]      d;
    logic [15:0]      x;
    logic             chk;
  } fcd_row_s;
  localparam logic [15:0] MK = 16'h00a1;
  localparam logic [15:0] DV = 16'h0b2c;
  localparam fcd_row_s ROWS [0:24] = '{
    '{fcd_pkg::OP_PROGRAM, 22'h000123, 16'h1234, 16'h1234, 1'b1},
    '{fcd_pkg::OP_READ, 22'h000123, 16'h0, 16'h1234, 1'b1},
    '{fcd_pkg::OP_READ, 22'h200123, 16'h0, 16'hffff, 1'b1},
    '{fcd_pkg::OP_AUTOSEL, 22'h000000, 16'h0, MK, 1'b1},
    '{fcd_pkg::OP_AUTOSEL, 22'h000001, 16'h0, DV, 1'b1},
    '{fcd_pkg::OP_AUTOSEL, 22'h208002, 16'h0, 16'h0000, 1'b1},
    '{fcd_pkg::OP_AUTOSEL, 22'h000003, 16'h0, 16'h0018, 1'b1},
    '{fcd_pkg::OP_RESET, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_READ, 22'h000123, 16'h0, 16'h1234, 1'b1},
    '{fcd_pkg::OP_BYP_ENTER, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_BYP_PROG, 22'h000040, 16'h00a5, 16'h00a5, 1'b1},
    '{fcd_pkg::OP_BYP_EXIT, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_READ, 22'h000040, 16'h0, 16'h00a5, 1'b1},
    '{fcd_pkg::OP_SEC_ENTER, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_SEC_EXIT, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_CFI, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_SUSPEND, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_RESUME, 22'h0, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_SECT_ERASE, 22'h008000, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_SECT_ADD, 22'h010000, 16'h0, 16'h0, 1'b0},
    '{fcd_pkg::OP_ERASE_WAIT, 22'h008000, 16'h0, 16'hffff, 1'b1},
    '{fcd_pkg::OP_READ, 22'h000123, 16'h0, 16'hffff, 1'b1},
    '{fcd_pkg::OP_PROGRAM, 22'h000123, 16'h00a5, 16'h00a5, 1'b1},
    '{fcd_pkg::OP_CHIP_ERASE, 22'h0, 16'h0, 16'hffff, 1'b1},
    '{fcd_pkg::OP_READ, 22'h000123, 16'h0, 16'hffff, 1'b1}};
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             cmd_valid = 1'b0;
  logic             cmd_ready;
  fcd_pkg::fcd_op_e cmd_op = fcd_pkg::OP_READ;
  logic [21:0]      cmd_addr = 22'h0;
  logic [15:0]      cmd_data = 16'h0;
  logic             rsp_valid;
  logic             rsp_fail;
  logic [15:0]      rsp_data;
  logic [21:0]      fl_addr;
  logic [15:0]      fl_dq_out;
  logic             fl_dq_oe_n;
  logic [15:0]      fl_dq_in;
  logic             fl_ce_n;
  logic             fl_we_n;
  logic             fl_oe_n;
  logic             fl_rst_n;
  int               n_mismatch = 0;
  int               comparisons = 0;
  always #4 clock = ~clock;
  fcd_host fcd_host_i (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .rsp_data(rsp_data), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_rst_n(fl_rst_n));
  fcd_flash_model #(.MAKER_ID(MK), .DEV_ID(DV), .BAD_A(22'h0003ff)) fcd_flash_model_i (
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_rst_n(fl_rst_n), .fl_dq_in(fl_dq_in));
  task automatic stop_test;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(input fcd_row_s r, input logic f);
    int n;
    cmd_op = r.op; cmd_addr = r.a; cmd_data = r.d; cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin @(negedge clock); n++; end
    comparisons++;
    if (rsp_valid !== 1'b1 || rsp_fail !== f || (r.chk && rsp_data !== r.x)) begin
      n_mismatch++;
      $display("ERROR t=%0t op=%0d data=%h fail=%b", $time, r.op, rsp_data, rsp_fail);
    end
    @(negedge clock);
  endtask
  initial begin
    repeat (10) @(negedge clock);
    comparisons++;
    if (fl_rst_n !== 1'b0 || cmd_ready !== 1'b1 || fl_we_n !== 1'b1 || fl_ce_n !== 1'b1) begin
      n_mismatch++;
      $display("ERROR t=%0t reset state wrong", $time);
    end
    rst = 1'b0;
    @(negedge clock);
    comparisons++;
    if (fl_rst_n !== 1'b1 || cmd_ready !== 1'b1 || rsp_valid !== 1'b0) begin
      n_mismatch++;
      $display("ERROR t=%0t state after reset release wrong", $time);
    end
    foreach (ROWS[i]) run(ROWS[i], 1'b0);
    run('{fcd_pkg::OP_PROGRAM, 22'h0003ff, 16'h0055, 16'h0, 1'b0}, 1'b1);
    run('{fcd_pkg::OP_READ, 22'h0003ff, 16'h0, 16'hffff, 1'b1}, 1'b0);
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule
